// file: rtl/mfp_pkg.sv
// Package for the translation fault prioritiser and table-cache parity.
// Assumes AXI4-Lite register access with 32-bit data on a single clock.
package mfp_pkg;

  // ----------------------------------------------------------------------
  // Register byte offsets
  // ----------------------------------------------------------------------
  localparam logic [7:0] MFP_CTRL_OFS = 8'h00;
  localparam logic [7:0] MFP_DBG_OFS = 8'h04;
  localparam logic [7:0] MFP_IFSR_OFS = 8'h08;
  localparam logic [7:0] MFP_DFSR_OFS = 8'h0c;
  localparam logic [7:0] MFP_IFAR_OFS = 8'h10;
  localparam logic [7:0] MFP_DFAR_OFS = 8'h14;
  localparam logic [7:0] MFP_STAT_OFS = 8'h18;

  // ----------------------------------------------------------------------
  // Field positions and reset values
  // ----------------------------------------------------------------------
  localparam int MFP_CTRL_ALIGN_BIT = 1;
  localparam int MFP_DBG_TLBMISS_BIT = 0;
  localparam int MFP_DBG_IMPRECISE_BIT = 1;
  localparam logic [31:0] MFP_CTRL_RST = 32'h0000_0000;
  localparam logic [31:0] MFP_DBG_RST = 32'h0000_0002;
  localparam int MFP_FSR_HI_BIT = 10;
  localparam int MFP_FSR_DOM_LSB = 4;
  localparam int MFP_STAT_DOMVALID_D = 1;
  localparam int MFP_STAT_DOMVALID_I = 0;

  // AXI responses
  localparam logic [1:0] MFP_RESP_OKAY = 2'h0;
  localparam logic [1:0] MFP_RESP_SLVERR = 2'h2;

  // ----------------------------------------------------------------------
  // Fault status codes: bit 10 then bits 3:0
  // ----------------------------------------------------------------------
  localparam logic [4:0] MFP_FS_IMPRECISE = 5'h16;
  localparam logic [4:0] MFP_FS_ALIGN = 5'h01;
  localparam logic [4:0] MFP_FS_TLBMISS = 5'h00;
  localparam logic [4:0] MFP_FS_L1_EXT = 5'h0c;
  localparam logic [4:0] MFP_FS_L1_TRANS = 5'h05;
  localparam logic [4:0] MFP_FS_L2_EXT = 5'h0e;
  localparam logic [4:0] MFP_FS_L2_TRANS = 5'h07;
  localparam logic [4:0] MFP_FS_SEC_DOM = 5'h09;
  localparam logic [4:0] MFP_FS_PAGE_DOM = 5'h0b;
  localparam logic [4:0] MFP_FS_SEC_PERM = 5'h0d;
  localparam logic [4:0] MFP_FS_PAGE_PERM = 5'h0f;
  localparam logic [4:0] MFP_FS_EXT = 5'h00;
  localparam logic [4:0] MFP_FS_DEBUG = 5'h02;

  // Fault request bit positions, index 12 is highest priority
  localparam int MFP_NFAULT = 13;
  localparam int MFP_F_IMPRECISE = 12;
  localparam int MFP_F_ALIGN = 11;
  localparam int MFP_F_TLBMISS = 10;
  localparam int MFP_F_L1_EXT = 9;
  localparam int MFP_F_L1_TRANS = 8;
  localparam int MFP_F_L2_EXT = 7;
  localparam int MFP_F_L2_TRANS = 6;
  localparam int MFP_F_SEC_DOM = 5;
  localparam int MFP_F_PAGE_DOM = 4;
  localparam int MFP_F_SEC_PERM = 3;
  localparam int MFP_F_PAGE_PERM = 2;
  localparam int MFP_F_EXT = 1;
  localparam int MFP_F_DEBUG = 0;
  // Faults at or above this index carry no valid domain
  localparam int MFP_F_DOM_INVALID_MIN = MFP_F_L1_TRANS;

  // Translation cache write data layout
  localparam int MFP_TWD_W = 112;
  localparam int MFP_TAG_PAR_W = 6;
  localparam int MFP_DATA_PAR_W = 10;

  typedef enum logic [1:0] {
    MFP_BUS_IDLE = 2'b00,
    MFP_BUS_RESP = 2'b01
  } mfp_bus_t;

endpackage

// file: rtl/mfp_fault_unit.sv
// Fault prioritiser, abort signalling, fault status/address capture and
// translation cache write parity, with an AXI4-Lite register slave.
// Assumes the pipeline, table walker and cache sit on the same clock.
//
// Notes on behaviour
// R1 - Report only top fault; alignment code 0001 then miss code 0000.
// R2 - Imprecise abort highest, bit10 set code 0110, address of load/store.
// R3 - Level 1 walk bus error 1100, then level 1 section missing 0101.
// R4 - Level 2 walk bus error 1110, then level 2 page missing 0111.
// R5 - Section domain 1001 above page domain; domains above permissions.
// R6 - Page domain 1011, page permission 1111 below section permission.
// R7 - Plain external abort 000 below permissions; debug event 0010 lowest.
// R8 - Domain invalid for imprecise, alignment, miss and level 1 faults.
// R9 - Masked lower faults are dropped, reappearing on instruction restart.
// R10 - Fault raises prefetch abort for fetches, data abort for data.
// R11 - Miss aborts only with abort-on-miss bit set; else table walk.
// R12 - Alignment faults only for data, only with alignment enable set.
// R13 - Alignment checking works with translation disabled.
// R14 - Miss, translation, domain, permission faults on fetch and data.
// R15 - Precise external aborts always reported, never masked.
// R16 - Imprecise aborts need enable bit, which resets enabled.
// R17 - Separate fetch/data status and address registers capture faults.
// R18 - One odd parity bit per byte of cache write data.
// R19 - System stores and checks parity; outputs may float.
// R20 - Write port: 22-bit tag, 34-bit data per way, 112 bits total.
// R21 - Tag parity 5..0 over 111:106,105:98,97:90,55:50,49:42,41:34.
// R22 - Data parity 9..0 over 89:88, bytes to 63:56, 33:32, bytes to 7:0.
// R23 - Walk bus error aborts, stops walk, writes no cache entry.
// R24 - Status and address update in the abort cycle.
`timescale 1ns/1ps

module mfp_fault_unit
  import mfp_pkg::*;
#(
  parameter int ADDR_W = 32,
  parameter int DOM_W = 4
) (
  // Clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // AXI4-Lite register slave
  input wire logic [7:0] s_axil_awaddr,
  input wire logic s_axil_awvalid,
  output logic s_axil_awready,
  input wire logic [31:0] s_axil_wdata,
  input wire logic [3:0] s_axil_wstrb,
  input wire logic s_axil_wvalid,
  output logic s_axil_wready,
  output logic [1:0] s_axil_bresp,
  output logic s_axil_bvalid,
  input wire logic s_axil_bready,
  input wire logic [7:0] s_axil_araddr,
  input wire logic s_axil_arvalid,
  output logic s_axil_arready,
  output logic [31:0] s_axil_rdata,
  output logic [1:0] s_axil_rresp,
  output logic s_axil_rvalid,
  input wire logic s_axil_rready,
  // Fetch side fault checks (one-cycle access strobe)
  input wire logic i_acc_valid,
  input wire logic [ADDR_W-1:0] i_modified_virtual_address,
  input wire logic [DOM_W-1:0] i_domain,
  input wire logic [MFP_NFAULT-1:0] i_fault_req,
  // Data side fault checks
  input wire logic d_acc_valid,
  input wire logic [ADDR_W-1:0] d_modified_virtual_address,
  input wire logic [DOM_W-1:0] d_domain,
  input wire logic [MFP_NFAULT-1:0] d_fault_req,
  input wire logic [1:0] d_size,
  // Table walker write request
  input wire logic walk_wr_valid,
  input wire logic walk_bus_error,
  input wire logic [MFP_TWD_W-1:0] walk_wr_data,
  // Aborts to the pipeline
  output logic prefetch_abort,
  output logic data_abort,
  output logic tlb_miss_walk,
  // Translation cache write port
  output logic tlb_write_en,
  output logic [MFP_TWD_W-1:0] tlb_write_data,
  output logic [MFP_TAG_PAR_W-1:0] tlb_tag_parity_out,
  output logic [MFP_DATA_PAR_W-1:0] tlb_data_parity_out
);

  // ----------------------------------------------------------------------
  // Software state
  // ----------------------------------------------------------------------
  logic [31:0] ctrl_reg;
  logic [31:0] dbg_reg;
  logic [10:0] ifsr_reg;
  logic [10:0] dfsr_reg;
  logic [ADDR_W-1:0] ifar_reg;
  logic [ADDR_W-1:0] dfar_reg;
  logic [1:0] domvalid_reg;

  wire align_en = ctrl_reg[MFP_CTRL_ALIGN_BIT];
  wire miss_abort_en = dbg_reg[MFP_DBG_TLBMISS_BIT];
  wire imprecise_en = dbg_reg[MFP_DBG_IMPRECISE_BIT];

  // ----------------------------------------------------------------------
  // Data alignment check, independent of translation enable
  // ----------------------------------------------------------------------
  // Size: 2'b10 word, 2'b01 halfword, 2'b00 byte (no check)
  wire d_misaligned = (d_size == 2'b10 && d_modified_virtual_address[1:0]
                       != 2'b00) || (d_size == 2'b01 &&
                       d_modified_virtual_address[0]);

  // ----------------------------------------------------------------------
  // Gating of enable-dependent faults
  // ----------------------------------------------------------------------
  // Fetch: no alignment fault at all; precise faults other than miss pass untouched
  logic [MFP_NFAULT-1:0] i_gated;
  logic [MFP_NFAULT-1:0] d_gated;
  always_comb begin
    i_gated = i_fault_req;                        // see R14 see R15
    i_gated[MFP_F_ALIGN] = 1'b0;                  // see R12
    i_gated[MFP_F_TLBMISS] = i_fault_req[MFP_F_TLBMISS]
                             & miss_abort_en;     // see R11
    i_gated[MFP_F_IMPRECISE] = i_fault_req[MFP_F_IMPRECISE]
                               & imprecise_en;    // see R16
    d_gated = d_fault_req;                        // see R14 see R15
    d_gated[MFP_F_ALIGN] = (d_fault_req[MFP_F_ALIGN] | d_misaligned)
                           & align_en;            // see R12 see R13
    d_gated[MFP_F_TLBMISS] = d_fault_req[MFP_F_TLBMISS] & miss_abort_en;
    d_gated[MFP_F_IMPRECISE] = d_fault_req[MFP_F_IMPRECISE] & imprecise_en;
  end

  // ----------------------------------------------------------------------
  // Priority encoder, shared by both sides
  // ----------------------------------------------------------------------
  // Only the top request is coded; the rest are dropped, not queued.
  function automatic logic [5:0] mfp_encode(
    input logic [MFP_NFAULT-1:0] req
  );
    logic [4:0] code;
    logic dv;
    code = MFP_FS_DEBUG;
    dv = 1'b1;
    if (req[MFP_F_IMPRECISE]) code = MFP_FS_IMPRECISE;      // see R2
    else if (req[MFP_F_ALIGN]) code = MFP_FS_ALIGN;         // see R1
    else if (req[MFP_F_TLBMISS]) code = MFP_FS_TLBMISS;     // see R1
    else if (req[MFP_F_L1_EXT]) code = MFP_FS_L1_EXT;       // see R3
    else if (req[MFP_F_L1_TRANS]) code = MFP_FS_L1_TRANS;   // see R3
    else if (req[MFP_F_L2_EXT]) code = MFP_FS_L2_EXT;       // see R4
    else if (req[MFP_F_L2_TRANS]) code = MFP_FS_L2_TRANS;   // see R4
    else if (req[MFP_F_SEC_DOM]) code = MFP_FS_SEC_DOM;     // see R5
    else if (req[MFP_F_PAGE_DOM]) code = MFP_FS_PAGE_DOM;   // see R6
    else if (req[MFP_F_SEC_PERM]) code = MFP_FS_SEC_PERM;   // see R5
    else if (req[MFP_F_PAGE_PERM]) code = MFP_FS_PAGE_PERM; // see R6
    else if (req[MFP_F_EXT]) code = MFP_FS_EXT;             // see R7
    else code = MFP_FS_DEBUG;                               // see R7
    // Domain not yet known for walk-front faults
    dv = ~|req[MFP_NFAULT-1:MFP_F_DOM_INVALID_MIN];         // see R8
    mfp_encode = {dv, code};                                // see R9
  endfunction

  // Encoded result per side; an abort fires only with its strobe
  wire [5:0] i_enc = mfp_encode(i_gated);
  wire [5:0] d_enc = mfp_encode(d_gated);
  wire i_fire = i_acc_valid && |i_gated;
  wire d_fire = d_acc_valid && |d_gated;
  wire d_miss_walk = d_acc_valid && d_fault_req[MFP_F_TLBMISS]
                     && !miss_abort_en;
  wire i_miss_walk = i_acc_valid && i_fault_req[MFP_F_TLBMISS]
                     && !miss_abort_en;
  // Status word layout: bit 10 high code bit, 7:4 domain, 3:0 code
  wire [10:0] i_fsr_next = {i_enc[4], 2'b00, i_domain, i_enc[3:0]};
  wire [10:0] d_fsr_next = {d_enc[4], 2'b00, d_domain, d_enc[3:0]};

  // ----------------------------------------------------------------------
  // Abort outputs and fault capture
  // ----------------------------------------------------------------------
  // Registered together so status and address land with the abort.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      prefetch_abort <= 1'b0;
      data_abort <= 1'b0;
      tlb_miss_walk <= 1'b0;
      ifsr_reg <= '0;
      dfsr_reg <= '0;
      ifar_reg <= '0;
      dfar_reg <= '0;
      domvalid_reg <= '0;
    end else begin
      prefetch_abort <= i_fire;                   // see R10
      data_abort <= d_fire;                       // see R10
      tlb_miss_walk <= i_miss_walk | d_miss_walk; // see R11
      if (i_fire) begin
        ifsr_reg <= i_fsr_next;                   // see R17 see R24
        ifar_reg <= i_modified_virtual_address;   // see R2 see R17
        domvalid_reg[MFP_STAT_DOMVALID_I] <= i_enc[5];
      end
      if (d_fire) begin
        dfsr_reg <= d_fsr_next;                   // see R17 see R24
        dfar_reg <= d_modified_virtual_address;   // see R2 see R17
        domvalid_reg[MFP_STAT_DOMVALID_D] <= d_enc[5];
      end
    end
  end

  // ----------------------------------------------------------------------
  // Translation cache write port with odd parity
  // ----------------------------------------------------------------------
  // Field bounds: tag 111:106,105:98,97:90,55:50,49:42,41:34
  localparam int TAG_HI [MFP_TAG_PAR_W] = '{41, 49, 55, 97, 105, 111};
  localparam int TAG_LO [MFP_TAG_PAR_W] = '{34, 42, 50, 90, 98, 106};
  localparam int DAT_HI [MFP_DATA_PAR_W] =
    '{7, 15, 23, 31, 33, 63, 71, 79, 87, 89};
  localparam int DAT_LO [MFP_DATA_PAR_W] =
    '{0, 8, 16, 24, 32, 56, 64, 72, 80, 88};

  // Bit set when a field holds an even count, so each word is odd
  logic [MFP_TAG_PAR_W-1:0] tag_par;
  logic [MFP_DATA_PAR_W-1:0] dat_par;
  genvar g;
  generate
    for (g = 0; g < MFP_TAG_PAR_W; g++) begin : g_tag_par
      assign tag_par[g] = ~^walk_wr_data[TAG_HI[g]:TAG_LO[g]]; // see R21
    end
    for (g = 0; g < MFP_DATA_PAR_W; g++) begin : g_dat_par
      assign dat_par[g] = ~^walk_wr_data[DAT_HI[g]:DAT_LO[g]]; // see R22
    end
  endgenerate

  // A faulting descriptor fetch never reaches the cache.
  wire walk_write = walk_wr_valid && !walk_bus_error;  // see R23

  // Data and parity held between writes to save toggling
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      tlb_write_en <= 1'b0;
      tlb_write_data <= '0;
      tlb_tag_parity_out <= '0;
      tlb_data_parity_out <= '0;
    end else begin
      tlb_write_en <= walk_write;
      if (walk_write) begin
        tlb_write_data <= walk_wr_data;           // see R20
        tlb_tag_parity_out <= tag_par;            // see R18
        tlb_data_parity_out <= dat_par;           // see R18
      end
    end
  end

  // ----------------------------------------------------------------------
  // AXI4-Lite write channel
  // ----------------------------------------------------------------------
  // Address and data latched independently; response after both.
  logic aw_held_reg;
  logic w_held_reg;
  logic [7:0] awaddr_reg;
  logic [31:0] wdata_reg;
  logic [3:0] wstrb_reg;
  wire wr_go = aw_held_reg && w_held_reg && !s_axil_bvalid;
  wire wr_ctrl = awaddr_reg == MFP_CTRL_OFS;
  wire wr_dbg = awaddr_reg == MFP_DBG_OFS;
  wire wr_known = wr_ctrl || wr_dbg || awaddr_reg == MFP_IFSR_OFS ||
                  awaddr_reg == MFP_DFSR_OFS ||
                  awaddr_reg == MFP_IFAR_OFS ||
                  awaddr_reg == MFP_DFAR_OFS ||
                  awaddr_reg == MFP_STAT_OFS;
  // Byte strobes widened to a bit mask
  logic [31:0] wmask;
  always_comb begin
    for (int i = 0; i < 4; i++) begin
      wmask[i*8 +: 8] = {8{wstrb_reg[i]}};
    end
  end

  // Handshakes and register update; status words stay read-only
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_held_reg <= 1'b0;
      w_held_reg <= 1'b0;
      awaddr_reg <= '0;
      wdata_reg <= '0;
      wstrb_reg <= '0;
      s_axil_awready <= 1'b0;
      s_axil_wready <= 1'b0;
      s_axil_bvalid <= 1'b0;
      s_axil_bresp <= MFP_RESP_OKAY;
      ctrl_reg <= MFP_CTRL_RST;
      dbg_reg <= MFP_DBG_RST;                     // see R16
    end else begin
      s_axil_awready <= !aw_held_reg && !s_axil_awready;
      s_axil_wready <= !w_held_reg && !s_axil_wready;
      if (s_axil_awvalid && s_axil_awready) begin
        aw_held_reg <= 1'b1;
        awaddr_reg <= s_axil_awaddr;
      end
      if (s_axil_wvalid && s_axil_wready) begin
        w_held_reg <= 1'b1;
        wdata_reg <= s_axil_wdata;
        wstrb_reg <= s_axil_wstrb;
      end
      if (wr_go) begin
        aw_held_reg <= 1'b0;
        w_held_reg <= 1'b0;
        s_axil_bvalid <= 1'b1;
        s_axil_bresp <= wr_known ? MFP_RESP_OKAY : MFP_RESP_SLVERR;
        if (wr_ctrl) ctrl_reg <= (ctrl_reg & ~wmask) | (wdata_reg & wmask);
        if (wr_dbg) dbg_reg <= (dbg_reg & ~wmask) | (wdata_reg & wmask);
      end else if (s_axil_bvalid && s_axil_bready) begin
        s_axil_bvalid <= 1'b0;
      end
    end
  end

  // ----------------------------------------------------------------------
  // AXI4-Lite read channel
  // ----------------------------------------------------------------------
  // Decode straight off the address; unmapped reads return zero
  logic [31:0] rd_word;
  logic rd_known;
  always_comb begin
    rd_known = 1'b1;
    case (s_axil_araddr)
      MFP_CTRL_OFS: rd_word = ctrl_reg;
      MFP_DBG_OFS: rd_word = dbg_reg;
      MFP_IFSR_OFS: rd_word = {21'h0, ifsr_reg};
      MFP_DFSR_OFS: rd_word = {21'h0, dfsr_reg};
      MFP_IFAR_OFS: rd_word = 32'(ifar_reg);
      MFP_DFAR_OFS: rd_word = 32'(dfar_reg);
      MFP_STAT_OFS: rd_word = {30'h0, domvalid_reg};
      default: begin
        rd_word = 32'h0000_0000;
        rd_known = 1'b0;
      end
    endcase
  end

  // One read at a time: address ready stays low while data waits
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axil_arready <= 1'b0;
      s_axil_rvalid <= 1'b0;
      s_axil_rdata <= '0;
      s_axil_rresp <= MFP_RESP_OKAY;
    end else begin
      s_axil_arready <= !s_axil_rvalid && !s_axil_arready;
      if (s_axil_arvalid && s_axil_arready) begin
        s_axil_rvalid <= 1'b1;
        s_axil_rdata <= rd_word;
        s_axil_rresp <= rd_known ? MFP_RESP_OKAY : MFP_RESP_SLVERR;
      end else if (s_axil_rvalid && s_axil_rready) begin
        s_axil_rvalid <= 1'b0;
      end
    end
  end

endmodule

// file: test/mfp_checker_assertions.sv
// Checker for the fault unit: abort timing, cache writes and parity.
// Bound into every fault unit instance; it sees that unit's ports only.
`timescale 1ns/1ps

module mfp_checker
  import mfp_pkg::*;
(
  // Clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // Access and walker inputs
  input wire logic i_acc_valid,
  input wire logic [MFP_NFAULT-1:0] i_fault_req,
  input wire logic d_acc_valid,
  input wire logic [MFP_NFAULT-1:0] d_fault_req,
  input wire logic walk_wr_valid,
  input wire logic walk_bus_error,
  input wire logic [MFP_TWD_W-1:0] walk_wr_data,
  // Design outputs
  input wire logic prefetch_abort,
  input wire logic data_abort,
  input wire logic tlb_miss_walk,
  input wire logic tlb_write_en,
  input wire logic [MFP_TWD_W-1:0] tlb_write_data,
  input wire logic [MFP_TAG_PAR_W-1:0] tlb_tag_parity_out,
  input wire logic [MFP_DATA_PAR_W-1:0] tlb_data_parity_out
);
  // -----------------------------------------------------------------
  // Properties
  // -----------------------------------------------------------------
  default clocking cb @(posedge aclk);
  endclocking
  default disable iff (!aresetn);
  // Short alias keeps the parity lines under the width limit
  wire logic [MFP_TWD_W-1:0] w = tlb_write_data;

  AST_D_ABORT: assert property (d_acc_valid && (|d_fault_req[9:0])
    |=> data_abort) else $error("data abort missing");
  AST_I_ABORT: assert property (i_acc_valid && (|i_fault_req[9:0])
    |=> prefetch_abort) else $error("prefetch abort missing");
  AST_D_CAUSE: assert property (data_abort |-> $past(d_acc_valid))
    else $error("data abort without access");
  AST_I_NOALIGN: assert property (i_acc_valid
    && i_fault_req == 13'h0800 |=> !prefetch_abort)
    else $error("alignment abort on fetch");
  AST_WALK_CAUSE: assert property (tlb_miss_walk
    |-> $past(d_acc_valid || i_acc_valid)) else $error("stray walk");
  AST_WR: assert property (walk_wr_valid && !walk_bus_error
    |=> tlb_write_en && tlb_write_data == $past(walk_wr_data))
    else $error("cache write lost");
  AST_BUSERR: assert property (walk_bus_error |=> !tlb_write_en)
    else $error("cache write after bus error");
  AST_TAGPAR: assert property (tlb_write_en |-> tlb_tag_parity_out ==
    {~^w[111:106], ~^w[105:98], ~^w[97:90], ~^w[55:50], ~^w[49:42],
     ~^w[41:34]}) else $error("tag parity wrong");
  AST_DATPAR: assert property (tlb_write_en |-> tlb_data_parity_out ==
    {~^w[89:88], ~^w[87:80], ~^w[79:72], ~^w[71:64], ~^w[63:56],
     ~^w[33:32], ~^w[31:24], ~^w[23:16], ~^w[15:8], ~^w[7:0]})
    else $error("data parity wrong");
endmodule

bind mfp_fault_unit mfp_checker i_mfp_checker (.*);

// file: test/mfp_cache_store.sv
// Model of the system's cache parity store, which keeps and checks bits.
// Assumes the write port of the fault unit on the same clock.
`timescale 1ns/1ps

module mfp_cache_store
  import mfp_pkg::*;
(
  // Clock
  input wire logic aclk,
  // Cache write port
  input wire logic tlb_write_en,
  input wire logic [MFP_TWD_W-1:0] tlb_write_data,
  input wire logic [MFP_TAG_PAR_W-1:0] tlb_tag_parity_out,
  input wire logic [MFP_DATA_PAR_W-1:0] tlb_data_parity_out,
  // Counts for the bench
  output int n_wr,
  output int n_bad
);
  logic [127:0] store_q [$];
  logic [15:0] p;

  // The system, not the unit, checks parity on every stored entry
  always @(posedge aclk) begin
    if (tlb_write_en === 1'b1) begin
      store_q.push_back({tlb_tag_parity_out, tlb_data_parity_out,
                         tlb_write_data});
      p = {tlb_tag_parity_out, tlb_data_parity_out};
      n_wr++;
      if ($isunknown(p)) n_bad++;
      for (int b = 0; b < 16; b++) begin
        if (!odd_ok(b)) n_bad++;
      end
    end
  end

  // Field b with its bit must hold an odd count of ones
  function automatic bit odd_ok(input int b);
    logic [MFP_TWD_W-1:0] d;
    int lo [16];
    int wd [16];
    d = tlb_write_data;
    lo = '{0, 8, 16, 24, 32, 56, 64, 72, 80, 88, 34, 42, 50, 90, 98, 106};
    wd = '{8, 8, 8, 8, 2, 8, 8, 8, 8, 2, 8, 8, 6, 8, 8, 6};
    return ((^((d >> lo[b]) & ((112'h1 << wd[b]) - 1))) ^ p[b]) === 1'b1;
  endfunction
endmodule

// file: test/mfp_fault_unit_bench.sv
// Bench for the fault unit: registers, priority, gating, cache writes.
// Assumes the checker is bound and the parity store sits on the port.
`timescale 1ns/1ps

module mfp_fault_unit_bench
  import mfp_pkg::*;
;
  logic aclk = 0, aresetn = 0;
  logic [7:0] s_axil_awaddr = 0, s_axil_araddr = 0;
  logic s_axil_awvalid = 0, s_axil_wvalid = 0, s_axil_bready = 0;
  logic s_axil_arvalid = 0, s_axil_rready = 0;
  logic [31:0] s_axil_wdata = 0;
  logic [3:0] s_axil_wstrb = 4'hf;
  logic s_axil_awready, s_axil_wready, s_axil_bvalid;
  logic s_axil_arready, s_axil_rvalid;
  logic [1:0] s_axil_bresp, s_axil_rresp;
  logic [31:0] s_axil_rdata;
  logic i_acc_valid = 0, d_acc_valid = 0;
  logic [31:0] i_modified_virtual_address = 0;
  logic [31:0] d_modified_virtual_address = 0;
  logic [3:0] i_domain = 0, d_domain = 0;
  logic [12:0] i_fault_req = 0, d_fault_req = 0;
  logic [1:0] d_size = 2'h2;
  logic walk_wr_valid = 0, walk_bus_error = 0;
  logic [111:0] walk_wr_data = 0;
  logic prefetch_abort, data_abort, tlb_miss_walk, tlb_write_en;
  logic [111:0] tlb_write_data;
  logic [5:0] tlb_tag_parity_out;
  logic [9:0] tlb_data_parity_out;
  int n_wr, n_bad, fail_count = 0, n_checks = 0, cyc = 0;
  logic [31:0] rv;
  logic [1:0] rr;
  logic [4:0] code [13];

  mfp_fault_unit i_mfp_fault_unit (.*);
  mfp_cache_store i_mfp_cache_store (.*);

  // ---------------------------------------------------------------
  // Clock, timeout and shared tasks
  // ---------------------------------------------------------------
  always #5 aclk = ~aclk;
  // Generous ceiling; the sequence needs well under a thousand cycles
  always @(posedge aclk) begin
    cyc++;
    if (cyc == 20000) begin
      fail_count++;
      end_sim();
    end
  end

  task chk(input string nm, input logic [31:0] s, input logic [31:0] e);
    n_checks++;
    if (s !== e) begin
      fail_count++;
      $display("wrong value %s expected %h seen %h", nm, e, s);
    end
  endtask

  task wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge aclk);
    s_axil_awaddr <= a;
    s_axil_wdata <= d;
    s_axil_awvalid <= 1'b1;
    s_axil_wvalid <= 1'b1;
    s_axil_bready <= 1'b1;
    do begin
      @(posedge aclk);
      if (s_axil_awvalid && s_axil_awready) s_axil_awvalid <= 1'b0;
      if (s_axil_wvalid && s_axil_wready) s_axil_wvalid <= 1'b0;
    end while (s_axil_bvalid !== 1'b1);
    s_axil_bready <= 1'b0;
    chk("bresp", s_axil_bresp, MFP_RESP_OKAY);
  endtask

  task rd(input logic [7:0] a);
    @(posedge aclk);
    s_axil_araddr <= a;
    s_axil_arvalid <= 1'b1;
    s_axil_rready <= 1'b1;
    do begin
      @(posedge aclk);
      if (s_axil_arvalid && s_axil_arready) s_axil_arvalid <= 1'b0;
    end while (s_axil_rvalid !== 1'b1);
    rv = s_axil_rdata;
    rr = s_axil_rresp;
    s_axil_rready <= 1'b0;
  endtask

  // One-cycle access strobe on one side, abort judged the cycle after
  task acc(input bit dside, input logic [12:0] q, input logic [31:0] a,
           input logic [1:0] sz, input logic ex);
    @(posedge aclk);
    d_acc_valid <= dside;
    i_acc_valid <= !dside;
    d_fault_req <= q;
    i_fault_req <= q;
    d_modified_virtual_address <= a;
    i_modified_virtual_address <= a;
    d_size <= sz;
    @(posedge aclk);
    d_acc_valid <= 1'b0;
    i_acc_valid <= 1'b0;
    #1;
    chk("abort", dside ? data_abort : prefetch_abort, ex);
    chk("other abort", dside ? prefetch_abort : data_abort, 1'b0);
  endtask

  // ---------------------------------------------------------------
  // Scenarios
  // ---------------------------------------------------------------
  task t_regs();
    rd(MFP_CTRL_OFS);
    chk("ctrl reset", rv, MFP_CTRL_RST);
    rd(MFP_DBG_OFS);
    chk("dbg reset", rv, 32'h2);
    rd(8'h40);
    chk("unmapped resp", rr, MFP_RESP_SLVERR);
  endtask

  // All faults from k down raised; only k may be recorded
  task t_prio();
    logic [31:0] m, e, a;
    wr(MFP_CTRL_OFS, 32'h2);
    wr(MFP_DBG_OFS, 32'h3);
    for (int k = 12; k >= 0; k--) begin
      a = 32'h1000 + k * 16;
      d_domain <= 4'(k);
      acc(1, 13'((32'h1 << (k + 1)) - 1), a, 2'h2, 1'b1);
      m = (k < MFP_F_DOM_INVALID_MIN) ? 32'h4ff : 32'h40f;
      e = {21'h0, code[k][4], 2'h0, 4'(k), code[k][3:0]};
      rd(MFP_DFSR_OFS);
      chk("dfsr", rv & m, e & m);
      rd(MFP_DFAR_OFS);
      chk("dfar", rv, a);
      rd(MFP_STAT_OFS);
      chk("dom valid", rv[1], k < MFP_F_DOM_INVALID_MIN);
    end
  endtask

  task t_gate();
    wr(MFP_CTRL_OFS, 32'h0);
    wr(MFP_DBG_OFS, 32'h0);
    acc(1, 13'h0800, 32'h10, 2'h2, 1'b0);
    acc(1, 13'h0400, 32'h10, 2'h2, 1'b0);
    chk("walk", tlb_miss_walk, 1'b1);
    acc(0, 13'h0400, 32'h10, 2'h2, 1'b0);
    chk("fetch walk", tlb_miss_walk, 1'b1);
    acc(1, 13'h1000, 32'h10, 2'h2, 1'b0);
    acc(1, 13'h0002, 32'h10, 2'h2, 1'b1);
    wr(MFP_CTRL_OFS, 32'h2);
    acc(1, 13'h0, 32'h21, 2'h1, 1'b1);
    acc(1, 13'h0, 32'h22, 2'h2, 1'b1);
    acc(1, 13'h0, 32'h23, 2'h0, 1'b0);
    rd(MFP_DFSR_OFS);
    chk("align code", rv & 32'h40f, MFP_FS_ALIGN);
    acc(0, 13'h0800, 32'h30, 2'h2, 1'b0);
    acc(0, 13'h0804, 32'h34, 2'h2, 1'b1);
    rd(MFP_IFSR_OFS);
    chk("ifsr", rv & 32'h40f, MFP_FS_PAGE_PERM);
    rd(MFP_IFAR_OFS);
    chk("ifar", rv, 32'h34);
    rd(MFP_DFAR_OFS);
    chk("dfar kept", rv, 32'h22);
  endtask

  // Back-to-back writes, then a bus error that must store nothing
  task t_cache();
    @(posedge aclk);
    walk_wr_valid <= 1'b1;
    walk_wr_data <= {14{8'ha5}};
    @(posedge aclk);
    walk_wr_data <= {56{2'b01}} ^ 112'h3;
    @(posedge aclk);
    walk_bus_error <= 1'b1;
    walk_wr_data <= '1;
    @(posedge aclk);
    walk_wr_valid <= 1'b0;
    walk_bus_error <= 1'b0;
    repeat (3) @(posedge aclk);
    chk("writes", n_wr, 2);
    chk("parity errs", n_bad, 0);
    chk("last data", tlb_write_data[31:0], 32'h55555556);
  endtask

  task end_sim();
    $display("checks %0d mismatches %0d", n_checks, fail_count);
    if (fail_count == 0 && n_checks > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask

  initial begin
    code = '{MFP_FS_DEBUG, MFP_FS_EXT, MFP_FS_PAGE_PERM, MFP_FS_SEC_PERM,
             MFP_FS_PAGE_DOM, MFP_FS_SEC_DOM, MFP_FS_L2_TRANS, MFP_FS_L2_EXT,
             MFP_FS_L1_TRANS, MFP_FS_L1_EXT, MFP_FS_TLBMISS, MFP_FS_ALIGN,
             MFP_FS_IMPRECISE};
    repeat (3) @(posedge aclk);
    aresetn <= 1'b1;
    repeat (2) @(posedge aclk);
    t_regs();
    t_prio();
    t_gate();
    t_cache();
    end_sim();
  end
endmodule
